/* dv/tb_twm_timer.sv */
// testbench: waveform timer driven over axi4-lite, pins watched by load models
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin n_fail++; \
  $display("BAD t=%0t got %h exp %h", $time, (a), (b)); end end

module tb_twm_timer;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [4:0] s_axi_awaddr = 5'h0, s_axi_araddr = 5'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf; // whole words only
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  twm_pkg::twm_pin_t pin_a, pin_b;
  logic lvl_a, lvl_b; // load levels
  logic [15:0] per_a, per_b, hi_a, hi_b, edg_a, edg_b; // load measurements
  int n_fail = 0;
  int compares = 0;

  always #25 aclk = ~aclk; // 20 mhz

  twm_timer dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .pin_a, .pin_b);
  twm_load_model u_load_a (.aclk, .pin(pin_a), .level(lvl_a), .period(per_a),
    .high_t(hi_a), .edges(edg_a));
  twm_load_model u_load_b (.aclk, .pin(pin_b), .level(lvl_b), .period(per_b),
    .high_t(hi_b), .edges(edg_b));

  ////////////////////////////////////////////////////////////////////////////
  // closing report, also reached by any wait that runs out
  task automatic conclude;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : conclude

  // write one word; address and data stay up until taken
  task automatic wr(input logic [4:0] a, input logic [31:0] d,
                    input logic [1:0] e = twm_pkg::RESP_OKAY);
    int i;
    @(posedge aclk);
    {s_axi_awaddr, s_axi_wdata} <= {a, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
    for (i = 0; i < 50; i++) begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) {s_axi_awvalid, s_axi_wvalid} <= 2'b00;
      if (s_axi_bvalid === 1'b1) begin
        `CHK(s_axi_bresp, e)
        s_axi_bready <= 1'b0;
        break;
      end
    end
    if (i == 50) begin
      n_fail++;
      conclude();
    end
  endtask : wr

  // read one word and compare data and response
  task automatic rd(input logic [4:0] a, input logic [31:0] e,
                    input logic [1:0] er = twm_pkg::RESP_OKAY);
    int i;
    @(posedge aclk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'b11;
    for (i = 0; i < 50; i++) begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) begin
        `CHK(s_axi_rdata, e)
        `CHK(s_axi_rresp, er)
        s_axi_rready <= 1'b0;
        break;
      end
    end
    if (i == 50) begin
      n_fail++;
      conclude();
    end
  endtask : rd

  // control word with both pins as outputs and the fastest timer clock
  function automatic logic [31:0] ctl(logic [2:0] m, logic [1:0] aa, logic [1:0] ab, logic lb);
    twm_pkg::twm_ctrl_t c;
    c = twm_pkg::CTRL_RESET;
    c.waveform_mode_select = m;
    c.output_a_action = aa;
    c.output_b_action = ab;
    {c.pin_dir_a, c.pin_dir_b, c.prescale, c.port_level_b} = {2'b11, 3'h1, lb};
    return {16'h0, c};
  endfunction : ctl

  // stopped in normal mode so compares load directly, then start
  task automatic go(logic [31:0] c, logic [7:0] ca, logic [7:0] cb, logic [7:0] n);
    wr(twm_pkg::ADDR_CTRL, 32'h0);
    wr(twm_pkg::ADDR_COUNT, {24'h0, n});
    wr(twm_pkg::ADDR_CMP_A, {24'h0, ca});
    wr(twm_pkg::ADDR_CMP_B, {24'h0, cb});
    wr(twm_pkg::ADDR_FLAGS, 32'h7);
    wr(twm_pkg::ADDR_CTRL, c);
  endtask : go

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    logic [15:0] e0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    rd(twm_pkg::ADDR_CTRL, 32'h0);
    rd(twm_pkg::ADDR_FLAGS, 32'h0);
    rd(5'h18, 32'h0, twm_pkg::RESP_SLVERR);
    wr(twm_pkg::ADDR_STATUS, 32'h1, twm_pkg::RESP_SLVERR);
    $display("test bus done");
    go(ctl(3'h2, 2'h1, 2'h0, 1'b1), 8'h09, 8'h00, 8'h00);
    repeat (100) @(posedge aclk);
    `CHK(per_a, 16'h0014)
    `CHK(pin_b.out, 1'b1)
    go(ctl(3'h2, 2'h1, 2'h0, 1'b0), 8'h00, 8'h00, 8'h00);
    repeat (20) @(posedge aclk);
    `CHK(per_a, 16'h0002)
    go(ctl(3'h2, 2'h1, 2'h0, 1'b0) & 32'hfffffdff, 8'h00, 8'h00, 8'h00);
    e0 = edg_a;
    repeat (20) @(posedge aclk);
    `CHK(edg_a, e0)
    `CHK(pin_a.oe, 1'b0)
    go(ctl(3'h2, 2'h0, 2'h0, 1'b0), 8'h10, 8'h00, 8'h80);
    repeat (60) @(posedge aclk);
    rd(twm_pkg::ADDR_FLAGS, 32'h0);
    repeat (150) @(posedge aclk);
    rd(twm_pkg::ADDR_FLAGS, 32'h7);
    wr(twm_pkg::ADDR_CTRL, 32'h0);
    wr(twm_pkg::ADDR_FLAGS, 32'h7);
    rd(twm_pkg::ADDR_FLAGS, 32'h0);
    go(ctl(3'h2, 2'h0, 2'h0, 1'b0), 8'h20, 8'h20, 8'h20);
    repeat (30) @(posedge aclk);
    rd(twm_pkg::ADDR_FLAGS, 32'h0);
    $display("test clear on match done");
    go(ctl(3'h3, 2'h2, 2'h3, 1'b0), 8'h40, 8'hc0, 8'h00);
    repeat (800) @(posedge aclk);
    `CHK(per_a, 16'h0100)
    `CHK(hi_a, 16'h0041)
    `CHK(hi_b, 16'h003f)
    rd(twm_pkg::ADDR_FLAGS, 32'h7);
    wr(twm_pkg::ADDR_CMP_A, 32'h80);
    rd(twm_pkg::ADDR_CMP_A, 32'h80);
    repeat (600) @(posedge aclk);
    `CHK(hi_a, 16'h0081)
    go(ctl(3'h3, 2'h2, 2'h0, 1'b0), 8'h00, 8'h00, 8'h00);
    repeat (600) @(posedge aclk);
    `CHK(hi_a, 16'h0001)
    go(ctl(3'h3, 2'h2, 2'h0, 1'b0), 8'hff, 8'h00, 8'h00);
    repeat (300) @(posedge aclk);
    e0 = edg_a;
    repeat (600) @(posedge aclk);
    `CHK(edg_a, e0)
    `CHK(pin_a.out, 1'b1)
    go(ctl(3'h7, 2'h1, 2'h1, 1'b1), 8'h13, 8'h05, 8'h00);
    repeat (200) @(posedge aclk);
    `CHK(per_a, 16'h0028)
    `CHK(pin_b.out, 1'b1)
    $display("test fast pwm done");
    go(ctl(3'h1, 2'h2, 2'h3, 1'b0), 8'h40, 8'h40, 8'h00);
    repeat (1200) @(posedge aclk);
    `CHK(per_a, 16'h01fe)
    `CHK(hi_a, 16'h0080)
    `CHK(hi_b, 16'h017e)
    rd(twm_pkg::ADDR_FLAGS, 32'h7);
    for (int v = 0; v < 2; v++) begin
      go(ctl(3'h1, 2'h2, 2'h0, 1'b0), v ? 8'hff : 8'h00, 8'h00, 8'h00);
      repeat (1100) @(posedge aclk);
      e0 = edg_a;
      repeat (1100) @(posedge aclk);
      `CHK(edg_a, e0)
      `CHK(pin_a.out, v[0])
    end
    go(ctl(3'h5, 2'h1, 2'h1, 1'b1), 8'h10, 8'h00, 8'h00);
    repeat (300) @(posedge aclk);
    `CHK(per_a, 16'h0040)
    `CHK(pin_b.out, 1'b1)
    $display("test phase correct done");
    conclude();
  end
endmodule : tb_twm_timer

/* dv/twm_load_model.sv */
// load model: pull-down load on one wave pin that measures period and high time
`timescale 1ns/1ps

module twm_load_model (
  // clock
  input wire logic aclk,
  // pin under load
  input wire twm_pkg::twm_pin_t pin,
  // measurements
  output logic level,
  output logic [15:0] period,
  output logic [15:0] high_t,
  output logic [15:0] edges
);
  logic lvl_q; // level one cycle ago
  logic [15:0] cyc_q; // free-running cycle count
  logic [15:0] rise_q; // cycle of the last rising edge
  logic [15:0] hi_q; // high cycles in the current period

  ////////////////////////////////////////////////////////////////////////////
  // a released pin falls to the pull-down, never keeps its last value
  assign level = pin.oe ? pin.out : 1'b0;

  initial begin
    {lvl_q, cyc_q, rise_q, hi_q, period, high_t, edges} = '0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // period and high time are latched at each rising edge of the load level
  always @(posedge aclk) begin
    cyc_q <= cyc_q + 16'h1;
    lvl_q <= level;
    if (level != lvl_q) begin
      edges <= edges + 16'h1;
    end
    if (level && !lvl_q) begin
      period <= cyc_q - rise_q;
      rise_q <= cyc_q;
      high_t <= hi_q;
      hi_q <= 16'h1;
    end else if (level) begin
      hi_q <= hi_q + 16'h1;
    end
  end
endmodule : twm_load_model

/* dv/twm_timer_chk.sv */
// checker: bus handshake, refusal and pin enable relations of the waveform timer
`timescale 1ns/1ps

module twm_timer_chk (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // write side
  input wire logic [4:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // read side
  input wire logic [4:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // pin
  input wire twm_pkg::twm_pin_t pin_a
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  ////////////////////////////////////////////////////////////////////////////
  // requests taken one cycle after they are offered
  property p_wr_take;
    s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid && !s_axi_awready
      |=> s_axi_awready && s_axi_wready && s_axi_bvalid;
  endproperty
  a_wr_take: assert property (p_wr_take) else $error("write not taken");
  property p_rd_take;
    s_axi_arvalid && !s_axi_rvalid && !s_axi_arready |=> s_axi_arready && s_axi_rvalid;
  endproperty
  a_rd_take: assert property (p_rd_take) else $error("read not taken");
  property p_ready_pulse;
    s_axi_awready |=> !s_axi_awready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("awready held");

  ////////////////////////////////////////////////////////////////////////////
  // answers stand until the master takes them
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read answer dropped");

  ////////////////////////////////////////////////////////////////////////////
  // refused places answer with an error and no data
  property p_rd_err;
    s_axi_arvalid && !s_axi_rvalid && !s_axi_arready && s_axi_araddr > twm_pkg::ADDR_STATUS
      |=> s_axi_rresp == twm_pkg::RESP_SLVERR && s_axi_rdata == 32'h0;
  endproperty
  a_rd_err: assert property (p_rd_err) else $error("unmapped read accepted");
  property p_wr_ro;
    s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid && !s_axi_awready
      && s_axi_awaddr == twm_pkg::ADDR_STATUS |=> s_axi_bresp == twm_pkg::RESP_SLVERR;
  endproperty
  a_wr_ro: assert property (p_wr_ro) else $error("status write accepted");

  ////////////////////////////////////////////////////////////////////////////
  // the pin driver only turns on or off as a result of a register write
  property p_oe_cause;
    $changed(pin_a.oe) |-> $past(s_axi_awready) || $past(s_axi_awready, 2);
  endproperty
  a_oe_cause: assert property (p_oe_cause) else $error("pin enable moved alone");
endmodule : twm_timer_chk

bind twm_timer twm_timer_chk u_chk (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
  .s_axi_rready, .pin_a);

/* hw/twm_pkg.sv */
// package: constants, register map and field layout of the timer waveform block
package twm_pkg;

  // register byte offsets on the axi4-lite bus
  localparam logic [4:0] ADDR_CTRL = 5'h00;
  localparam logic [4:0] ADDR_COUNT = 5'h04;
  localparam logic [4:0] ADDR_CMP_A = 5'h08;
  localparam logic [4:0] ADDR_CMP_B = 5'h0c;
  localparam logic [4:0] ADDR_FLAGS = 5'h10;
  localparam logic [4:0] ADDR_STATUS = 5'h14;

  // flag register bit positions
  localparam int FLAG_OVF = 0;
  localparam int FLAG_CMP_A = 1;
  localparam int FLAG_CMP_B = 2;

  // counting extremes
  localparam logic [7:0] CNT_BOTTOM = 8'h00;
  localparam logic [7:0] CNT_MAX = 8'hff;

  // waveform_mode_select codes
  localparam logic [2:0] MODE_NORMAL = 3'h0;
  localparam logic [2:0] MODE_PC_FF = 3'h1;
  localparam logic [2:0] MODE_CTC = 3'h2;
  localparam logic [2:0] MODE_FAST_FF = 3'h3;
  localparam logic [2:0] MODE_PC_CMPA = 3'h5;
  localparam logic [2:0] MODE_FAST_CMPA = 3'h7;

  // output action codes
  localparam logic [1:0] ACT_OFF = 2'h0;
  localparam logic [1:0] ACT_TOGGLE = 2'h1;
  localparam logic [1:0] ACT_CLEAR = 2'h2;
  localparam logic [1:0] ACT_SET = 2'h3;

  // prescaler: terminal counts for divide by 1, 8, 64, 256, 1024
  localparam logic [9:0] DIV1_LAST = 10'h000;
  localparam logic [9:0] DIV8_LAST = 10'h007;
  localparam logic [9:0] DIV64_LAST = 10'h03f;
  localparam logic [9:0] DIV256_LAST = 10'h0ff;
  localparam logic [9:0] DIV1024_LAST = 10'h3ff;

  // axi response codes
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // control register layout, low 16 bits of ADDR_CTRL
  typedef struct packed {
    logic port_level_b;   // [15] pin level when channel b is disconnected
    logic port_level_a;   // [14]
    logic [2:0] prescale; // [13:11] 0 stop, 1..5 = /1 /8 /64 /256 /1024
    logic pin_dir_b;      // [10] 1 = pin b is an output
    logic pin_dir_a;      // [9]
    logic [1:0] output_a_action;   // [8:7]
    logic [1:0] output_b_action;   // [6:5]
    logic [1:0] spare;             // [4:3] reads as written, no effect
    logic [2:0] waveform_mode_select; // [2:0]
  } twm_ctrl_t;

  localparam twm_ctrl_t CTRL_RESET = 16'h0000;

  // pin drive pair: level and output enable
  typedef struct packed {
    logic out;
    logic oe;
  } twm_pin_t;

endpackage : twm_pkg

/* hw/twm_timer.sv */
// module: 8-bit timer with clear-on-match, fast pwm and phase-correct pwm waveforms
// Overview of operation
// (RQ1) mode 2: clear count on channel a match
// (RQ2) ctc compare unbuffered; missed match wraps through 0xff
// (RQ3) ctc with action 1 toggles wave_out_a
// (RQ4) pin driven only when direction selects output
// (RQ5) ctc compare zero toggles every timer clock
// (RQ6) ctc overflow flag when count wraps max
// (RQ7) modes 3/7 count up only, top 0xff/cmpa
// (RQ8) fast pwm clears count tick after top
// (RQ9) fast pwm: clear/set on match, opposite bottom
// (RQ10) fast pwm toggle channel a only with msb
// (RQ11) fast pwm overflow flag at top
// (RQ12) compare double buffered in pwm, direct otherwise
// (RQ13) fast pwm top 0xff gives 256 clocks
// (RQ14) fast pwm extremes: spike or constant level
// (RQ15) modes 1/5 count up then down, repeatedly
// (RQ16) phase-correct holds top one tick, reverses
// (RQ17) phase-correct: up match clear, down match set
// (RQ18) phase-correct toggle channel a only with msb
// (RQ19) phase-correct overflow flag at bottom
// (RQ20) phase-correct top 0xff gives 510 clocks
// (RQ21) phase-correct extremes hold constant level
// (RQ22) phase-correct forced transition keeps bottom symmetry
// (RQ23) action 0 disconnects output, no action
// (RQ24) match sets compare flag; write one clears
// (RQ25) buffered compare loads at top only
// (RQ26) count write blocks matches next tick
//
// Chosen here: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps

module twm_timer (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire logic [4:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [4:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // wave pins
  output twm_pkg::twm_pin_t pin_a,
  output twm_pkg::twm_pin_t pin_b
);

  ////////////////////////////////////////////////////////////////////////////
  // register state
  twm_pkg::twm_ctrl_t ctrl_q;       // configuration
  logic [7:0] count_q;              // count_value
  logic up_q;                       // phase-correct direction, 1 = up
  logic block_q;                    // matches blocked until next tick
  logic [7:0] buf_q [2];            // compare values as software wrote them
  logic [7:0] cmp_q [2];            // active compare values
  logic [2:0] flags_q;              // overflow, compare a, compare b
  logic wave_q [2];                 // internal wave output state
  logic [9:0] pre_q;                // prescaler counter

  ////////////////////////////////////////////////////////////////////////////
  // bus handshake decode
  logic wr_go;
  logic rd_go;
  logic [31:0] wmask;
  logic [31:0] wr_ctrl;
  logic wr_count;
  logic [1:0] match;                // compare matches, one per channel

  // write taken only with address and data together, one at a time
  assign wr_go = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid && !s_axi_awready;
  assign rd_go = s_axi_arvalid && !s_axi_rvalid && !s_axi_arready;
  assign wmask = {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
                  {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
  assign wr_ctrl = ({16'h0000, ctrl_q} & ~wmask) | (s_axi_wdata & wmask);
  assign wr_count = wr_go && s_axi_awaddr == twm_pkg::ADDR_COUNT && s_axi_wstrb[0];

  ////////////////////////////////////////////////////////////////////////////
  // mode decode
  logic [2:0] mode;
  logic is_pc;
  logic is_fast;
  logic is_pwm;
  logic [7:0] top;
  logic tick;
  logic at_top;

  assign mode = ctrl_q.waveform_mode_select;
  assign is_pc = mode == twm_pkg::MODE_PC_FF || mode == twm_pkg::MODE_PC_CMPA; // RQ15
  assign is_fast = mode == twm_pkg::MODE_FAST_FF || mode == twm_pkg::MODE_FAST_CMPA; // RQ7
  assign is_pwm = is_pc || is_fast;
  // top follows channel a compare in modes 2, 5, 7, otherwise max
  assign top = (mode == twm_pkg::MODE_CTC || mode == twm_pkg::MODE_PC_CMPA ||
                mode == twm_pkg::MODE_FAST_CMPA) ? cmp_q[0] : twm_pkg::CNT_MAX;
  assign at_top = count_q == top;

  ////////////////////////////////////////////////////////////////////////////
  // prescaler: one-cycle timer tick, stopped when prescale is zero
  logic [9:0] pre_last;

  always_comb begin
    unique case (ctrl_q.prescale)
      3'h1: pre_last = twm_pkg::DIV1_LAST;
      3'h2: pre_last = twm_pkg::DIV8_LAST;
      3'h3: pre_last = twm_pkg::DIV64_LAST;
      3'h4: pre_last = twm_pkg::DIV256_LAST;
      default: pre_last = twm_pkg::DIV1024_LAST;
    endcase
  end

  assign tick = ctrl_q.prescale >= 3'h1 && ctrl_q.prescale <= 3'h5 && pre_q == pre_last;

  // free-running divider; held at zero while prescale is zero
  always_ff @(posedge aclk) begin
    if (!aresetn || ctrl_q.prescale == 3'h0) begin
      pre_q <= 10'h000;
    end else if (pre_q >= pre_last) begin
      pre_q <= 10'h000;
    end else begin
      pre_q <= pre_q + 10'h001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // counter: software write wins over counting
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_q <= twm_pkg::CNT_BOTTOM;
      up_q <= 1'b1;
    end else if (wr_count) begin
      count_q <= s_axi_wdata[7:0];
    end else if (tick) begin
      if (is_pc) begin
        // dual slope: top and bottom each held one tick
        if (up_q && at_top) begin
          up_q <= 1'b0;                                  // RQ16
          count_q <= count_q - 8'h01;
        end else if (!up_q && count_q == twm_pkg::CNT_BOTTOM) begin
          up_q <= 1'b1;                                  // RQ15
          count_q <= count_q + 8'h01;
        end else if (up_q) begin
          count_q <= count_q + 8'h01;
        end else begin
          count_q <= count_q - 8'h01;
        end
      end else if (is_fast || mode == twm_pkg::MODE_CTC) begin
        // single slope, restart from bottom the tick after top
        if (at_top) begin
          count_q <= twm_pkg::CNT_BOTTOM;                // RQ1 RQ8 RQ13
        end else begin
          count_q <= count_q + 8'h01;                    // RQ2 RQ7
        end
      end else begin
        count_q <= count_q + 8'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // match blocking after a count write, even while stopped
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      block_q <= 1'b0;
    end else if (wr_count) begin
      block_q <= 1'b1;                                   // RQ26
    end else if (tick) begin
      block_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // per-channel compare storage and wave generation
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_chan
      logic [1:0] act;
      logic toggle_ok;
      logic ignore;
      logic up_eq;
      logic wr_buf;

      assign act = (ch == 0) ? ctrl_q.output_a_action : ctrl_q.output_b_action;
      // toggle in pwm is offered on channel a with the mode msb only
      assign toggle_ok = !is_pwm || (ch == 0 && mode[2]);      // RQ10 RQ18
      assign match[ch] = tick && !block_q && count_q == cmp_q[ch];
      // channel a at top with clear/set action: match handled at the turn
      assign ignore = ch == 0 && is_pwm && act[1] && cmp_q[0] == top;
      // bottom counts as an up-going match in dual slope
      assign up_eq = up_q || count_q == twm_pkg::CNT_BOTTOM;
      assign wr_buf = wr_go && s_axi_wstrb[0] &&
                      s_axi_awaddr == ((ch == 0) ? twm_pkg::ADDR_CMP_A : twm_pkg::ADDR_CMP_B);

      // buffer written by software
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          buf_q[ch] <= twm_pkg::CNT_BOTTOM;
        end else if (wr_buf) begin
          buf_q[ch] <= s_axi_wdata[7:0];
        end
      end

      // active value: direct outside pwm, loaded at top inside pwm
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          cmp_q[ch] <= twm_pkg::CNT_BOTTOM;
        end else if (!is_pwm) begin
          cmp_q[ch] <= wr_buf ? s_axi_wdata[7:0] : buf_q[ch];  // RQ2 RQ12
        end else if (tick && at_top && (is_fast || up_q)) begin
          cmp_q[ch] <= buf_q[ch];                               // RQ12 RQ25
        end
      end

      // wave output register; action changes act at the next match, or at top for clear/set in pwm
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          wave_q[ch] <= 1'b0;
        end else if (tick && act != twm_pkg::ACT_OFF) begin   // RQ23
          if (is_fast) begin
            if (at_top && act[1]) begin
              wave_q[ch] <= ~act[0];                          // RQ9 RQ14
            end else if (match[ch] && !ignore) begin
              if (act[1]) begin
                wave_q[ch] <= act[0];                         // RQ9 RQ14
              end else if (toggle_ok) begin
                wave_q[ch] <= ~wave_q[ch];                    // RQ10
              end
            end
          end else if (is_pc) begin
            if (up_q && at_top && act[1] && (ignore || count_q > cmp_q[ch])) begin
              // turning at top: level as the down-going match leaves it when
              // compare sits at top, else as the up-going match that was missed
              wave_q[ch] <= ignore ? ~act[0] : act[0];       // RQ21 RQ22
            end else if (match[ch] && !ignore) begin
              if (act[1]) begin
                wave_q[ch] <= up_eq ? act[0] : ~act[0];       // RQ17 RQ21
              end else if (toggle_ok) begin
                wave_q[ch] <= ~wave_q[ch];                    // RQ18
              end
            end
          end else if (match[ch]) begin
            // normal and ctc: toggle, clear or set on every match
            unique case (act)
              twm_pkg::ACT_TOGGLE: wave_q[ch] <= ~wave_q[ch]; // RQ3 RQ5
              twm_pkg::ACT_CLEAR: wave_q[ch] <= 1'b0;
              default: wave_q[ch] <= 1'b1;
            endcase
          end
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // flags: hardware set wins over a write-one clear in the same cycle
  logic ovf_evt;

  assign ovf_evt = tick && (is_pc ? (!up_q && count_q == 8'h01)   // RQ19 RQ20
                                  : is_fast ? at_top               // RQ11
                                  : count_q == twm_pkg::CNT_MAX);  // RQ6

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flags_q <= 3'h0;
    end else begin
      flags_q <= (flags_q & ~((wr_go && s_axi_awaddr == twm_pkg::ADDR_FLAGS && s_axi_wstrb[0])
                              ? s_axi_wdata[2:0] : 3'h0))
                 | {match[1], match[0], ovf_evt};            // RQ24
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= twm_pkg::CTRL_RESET;
    end else if (wr_go && s_axi_awaddr == twm_pkg::ADDR_CTRL) begin
      ctrl_q <= wr_ctrl[15:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pins: wave state only when the action connects it, drive only as output
  logic [1:0] connect;

  assign connect[0] = ctrl_q.output_a_action[1] ||
                      (ctrl_q.output_a_action == twm_pkg::ACT_TOGGLE && (!is_pwm || mode[2]));
  assign connect[1] = ctrl_q.output_b_action[1] ||
                      (ctrl_q.output_b_action == twm_pkg::ACT_TOGGLE && !is_pwm);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_a <= 2'b00;
      pin_b <= 2'b00;
    end else begin
      pin_a.oe <= ctrl_q.pin_dir_a;                                    // RQ4
      pin_a.out <= connect[0] ? wave_q[0] : ctrl_q.port_level_a;       // RQ23
      pin_b.oe <= ctrl_q.pin_dir_b;                                    // RQ4
      pin_b.out <= connect[1] ? wave_q[1] : ctrl_q.port_level_b;       // RQ23
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // axi write channel: ready pulses with the take, response raised in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= twm_pkg::RESP_OKAY;
    end else begin
      s_axi_awready <= wr_go;
      s_axi_wready <= wr_go;
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        // status is read-only, unknown offsets are errors
        s_axi_bresp <= (s_axi_awaddr > twm_pkg::ADDR_FLAGS || s_axi_awaddr[1:0] != 2'h0)
                       ? twm_pkg::RESP_SLVERR : twm_pkg::RESP_OKAY;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // axi read channel: data registered with the address take
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= twm_pkg::RESP_OKAY;
    end else begin
      s_axi_arready <= rd_go;
      if (rd_go) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= twm_pkg::RESP_OKAY;
        unique case (s_axi_araddr)
          twm_pkg::ADDR_CTRL: s_axi_rdata <= {16'h0000, ctrl_q};
          twm_pkg::ADDR_COUNT: s_axi_rdata <= {24'h000000, count_q};
          twm_pkg::ADDR_CMP_A: s_axi_rdata <= {24'h000000, buf_q[0]};
          twm_pkg::ADDR_CMP_B: s_axi_rdata <= {24'h000000, buf_q[1]};
          twm_pkg::ADDR_FLAGS: s_axi_rdata <= {29'h00000000, flags_q};
          twm_pkg::ADDR_STATUS: s_axi_rdata <= {29'h00000000, up_q, wave_q[1], wave_q[0]};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= twm_pkg::RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule : twm_timer
